// ---- pieb_defs.vh ----
// register map, field positions and reset values of the peripheral interrupt enable bank
`ifndef PIEB_DEFS_VH
`define PIEB_DEFS_VH

`define PIEB_ADR_W        8
`define PIEB_OFS_EN1      8'h00
`define PIEB_OFS_EN2      8'h04
`define PIEB_OFS_EN3      8'h08
`define PIEB_OFS_EN4      8'h0c
`define PIEB_OFS_EN5      8'h10
`define PIEB_OFS_STAT     8'h14
`define PIEB_OFS_CLR      8'h18
`define PIEB_OFS_IRQEN    8'h1c
`define PIEB_OFS_CTRL     8'h20

`define PIEB_EN_RST       8'h00
`define PIEB_CTRL_RST     2'h0
`define PIEB_EV_RST       3'h0

`define PIEB_WMASK1       8'h7f
`define PIEB_WMASK2       8'hbf
`define PIEB_WMASK3       8'hcf
`define PIEB_WMASK4       8'hff
`define PIEB_WMASK5       8'hff
`define PIEB_WMASK4_SMALL 8'h3f
`define PIEB_WMASK5_SMALL 8'h17

`define PIEB_EN1_RX1      5
`define PIEB_EN1_TX1      4
`define PIEB_EN3_DISP     6
`define PIEB_EN3_RX2      5
`define PIEB_EN3_TX2      4

`define PIEB_CTRL_GLOBAL  0
`define PIEB_CTRL_PRIO    1

`define PIEB_EV_W         3
`define PIEB_EV_REQ_RISE  0
`define PIEB_EV_RO_WRITE  1
`define PIEB_EV_UNMAPPED  2

`endif

// ---- pieb_wb_slave.v ----
// classic wishbone handshake: one-wait-state ack and access strobes
`timescale 1ns/100ps
module pieb_wb_slave (
  input  wire i_clk,      // system clock
  input  wire i_rst,      // synchronous reset, active high
  input  wire i_cyc,      // bus cycle
  input  wire i_stb,      // strobe
  input  wire i_we,       // write enable
  output wire o_ack,      // acknowledge, one cycle
  output wire o_start,    // first cycle of an access
  output wire o_wr        // write commit, same edge as ack
);

  reg  ack_ff;
  wire nxt_ack;

  // ack one cycle after the request, dropped the cycle after
  assign nxt_ack = i_cyc & i_stb & ~ack_ff;

  always @(posedge i_clk) begin
    if (i_rst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= nxt_ack;
    end
  end

  assign o_ack   = ack_ff;
  assign o_start = nxt_ack;
  assign o_wr    = ack_ff & i_cyc & i_stb & i_we;

endmodule // pieb_wb_slave

// ---- pieb_top.v ----
// peripheral interrupt enable bank with wishbone registers and summary interrupt
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "pieb_defs.vh"

// Operation
// (RULE1) first register: bit7 unused, bits6..0 sources
// (RULE2) second register: osc fail down to timer3 gate
// (RULE3) third register: timer5 gate down to real-time clock
// (RULE4) fourth register: capture/compare channels ten to three
// (RULE5) fifth register: timer7 gate down to timer4 match
// (RULE6) enable one passes source, zero blocks it
// (RULE7) unused bits always read zero
// (RULE8) serial2 rx/tx enables read-only, reset zero
// (RULE9) display enable only in type-B multiplexed mode
// (RULE10) small variant lacks channel ten, nine enables
// (RULE11) small variant lacks four timer enables
// (RULE12) without priority scheme, global enable also required
// (RULE13) software clears event flags itself
// (RULE14) serial flags drop on buffer read/write
// (RULE15) request is OR of flag AND enable
// (RULE16) writes to unimplemented positions are ignored
module pieb_top #(
  parameter SMALL_VARIANT = 0                 // 1: 32 Kbyte program memory part
) (
  input  wire        I_CLK,                   // system clock, 10 MHz
  input  wire        I_SYS_RST,               // synchronous reset, active high
  input  wire        I_WB_CYC,                // wishbone cycle
  input  wire        I_WB_STB,                // wishbone strobe
  input  wire        I_WB_WE,                 // wishbone write enable
  input  wire [7:0]  I_WB_ADR,                // wishbone byte address
  input  wire [3:0]  I_WB_SEL,                // wishbone byte selects
  input  wire [31:0] I_WB_DAT,                // wishbone write data
  output wire [31:0] O_WB_DAT,                // wishbone read data
  output wire        O_WB_ACK,                // wishbone acknowledge
  input  wire [7:0]  I_FLAG1,                 // flag register 1 contents
  input  wire [7:0]  I_FLAG2,                 // flag register 2 contents
  input  wire [7:0]  I_FLAG3,                 // flag register 3 contents
  input  wire [7:0]  I_FLAG4,                 // flag register 4 contents
  input  wire [7:0]  I_FLAG5,                 // flag register 5 contents
  input  wire [1:0]  I_RX_BUF_RD,             // serial rx buffer read pulse, [1]=port2
  input  wire [1:0]  I_TX_BUF_WR,             // serial tx buffer write pulse, [1]=port2
  input  wire        I_DISP_TYPE_B,           // display runs second waveform type
  input  wire        I_DISP_NONSTATIC,        // display in multiplexed drive
  output wire [7:0]  O_GATED1,                // flag and enable, register 1
  output wire [7:0]  O_GATED2,                // flag and enable, register 2
  output wire [7:0]  O_GATED3,                // flag and enable, register 3
  output wire [7:0]  O_GATED4,                // flag and enable, register 4
  output wire [7:0]  O_GATED5,                // flag and enable, register 5
  output wire        O_PERIPH_REQ,            // peripheral request to core
  output wire        O_IRQ                    // summary interrupt, level
);

  ////////////////////////////////////////////////////////////////////////////////
  // write masks per register

  function [7:0] wmask;
    input [7:0] ofs;
    input       is_small;
    begin
      case (ofs)
        `PIEB_OFS_EN1: wmask = `PIEB_WMASK1;                           // RULE1
        `PIEB_OFS_EN2: wmask = `PIEB_WMASK2;                           // RULE2
        `PIEB_OFS_EN3: wmask = `PIEB_WMASK3;                           // RULE8
        `PIEB_OFS_EN4: wmask = is_small ? `PIEB_WMASK4_SMALL : `PIEB_WMASK4; // RULE10
        `PIEB_OFS_EN5: wmask = is_small ? `PIEB_WMASK5_SMALL : `PIEB_WMASK5; // RULE11
        default:       wmask = 8'h00;
      endcase
    end
  endfunction

  function is_mapped;
    input [7:0] ofs;
    begin
      case (ofs)
        `PIEB_OFS_EN1, `PIEB_OFS_EN2, `PIEB_OFS_EN3, `PIEB_OFS_EN4,
        `PIEB_OFS_EN5, `PIEB_OFS_STAT, `PIEB_OFS_CLR, `PIEB_OFS_IRQEN,
        `PIEB_OFS_CTRL: is_mapped = 1'b1;
        default:        is_mapped = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake

  wire       start;
  wire       wr;
  wire [7:0] adr_w;
  wire [7:0] wdat;
  wire       lane0;
  wire [7:0] cur_mask;
  wire       small_sel;

  pieb_wb_slave u_wb (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_cyc   (I_WB_CYC),
    .i_stb   (I_WB_STB),
    .i_we    (I_WB_WE),
    .o_ack   (O_WB_ACK),
    .o_start (start),
    .o_wr    (wr)
  );

  assign small_sel = (SMALL_VARIANT != 0);
  assign adr_w     = {I_WB_ADR[7:2], 2'b00};
  assign wdat      = I_WB_DAT[7:0];
  assign lane0     = I_WB_SEL[0];
  assign cur_mask  = wmask(adr_w, small_sel);

  ////////////////////////////////////////////////////////////////////////////////
  // enable and control registers

  reg  [7:0] en1_ff;
  reg  [7:0] en2_ff;
  reg  [7:0] en3_ff;
  reg  [7:0] en4_ff;
  reg  [7:0] en5_ff;
  reg  [1:0] ctrl_ff;
  reg  [`PIEB_EV_W-1:0] irqen_ff;
  wire [7:0] wmerge;

  // only implemented, writable positions take write data
  assign wmerge = wdat & cur_mask; // RULE16

  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      en1_ff   <= `PIEB_EN_RST;
      en2_ff   <= `PIEB_EN_RST;
      en3_ff   <= `PIEB_EN_RST; // RULE8
      en4_ff   <= `PIEB_EN_RST;
      en5_ff   <= `PIEB_EN_RST;
      ctrl_ff  <= `PIEB_CTRL_RST;
      irqen_ff <= `PIEB_EV_RST;
    end else if (wr && lane0) begin
      case (adr_w)
        `PIEB_OFS_EN1:   en1_ff   <= wmerge; // RULE1
        `PIEB_OFS_EN2:   en2_ff   <= wmerge; // RULE2
        `PIEB_OFS_EN3:   en3_ff   <= wmerge; // RULE3
        `PIEB_OFS_EN4:   en4_ff   <= wmerge; // RULE4
        `PIEB_OFS_EN5:   en5_ff   <= wmerge; // RULE5
        `PIEB_OFS_CTRL:  ctrl_ff  <= wdat[1:0];
        `PIEB_OFS_IRQEN: irqen_ff <= wdat[`PIEB_EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gating of the peripheral flags

  reg  [7:0] flag1_eff;
  reg  [7:0] flag3_eff;
  wire [7:0] en3_eff;
  wire       disp_ok;
  wire       any_pend;
  wire       pass_global;

  // serial flags are buffer levels; drop them in the access cycle already
  always @* begin
    flag1_eff = I_FLAG1;
    flag3_eff = I_FLAG3;
    if (I_RX_BUF_RD[0]) begin
      flag1_eff[`PIEB_EN1_RX1] = 1'b0; // RULE14
    end
    if (I_TX_BUF_WR[0]) begin
      flag1_eff[`PIEB_EN1_TX1] = 1'b0; // RULE14
    end
    if (I_RX_BUF_RD[1]) begin
      flag3_eff[`PIEB_EN3_RX2] = 1'b0; // RULE14
    end
    if (I_TX_BUF_WR[1]) begin
      flag3_eff[`PIEB_EN3_TX2] = 1'b0; // RULE14
    end
  end

  assign disp_ok = I_DISP_TYPE_B & I_DISP_NONSTATIC; // RULE9
  assign en3_eff = {en3_ff[7], en3_ff[6] & disp_ok, en3_ff[5:0]}; // RULE9

  // event flags are held outside; this bank never clears them (RULE13)
  assign O_GATED1 = flag1_eff & en1_ff; // RULE6
  assign O_GATED2 = I_FLAG2   & en2_ff; // RULE6
  assign O_GATED3 = flag3_eff & en3_eff; // RULE6
  assign O_GATED4 = I_FLAG4   & en4_ff; // RULE6
  assign O_GATED5 = I_FLAG5   & en5_ff; // RULE6

  assign any_pend = |{O_GATED1, O_GATED2, O_GATED3, O_GATED4, O_GATED5}; // RULE15
  // with the priority scheme on, the global gate lives in the core logic
  assign pass_global  = ctrl_ff[`PIEB_CTRL_PRIO] | ctrl_ff[`PIEB_CTRL_GLOBAL]; // RULE12
  assign O_PERIPH_REQ = any_pend & pass_global; // RULE12

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status and summary interrupt

  reg  [`PIEB_EV_W-1:0] stat_ff;
  reg                   req_d_ff;
  reg  [`PIEB_EV_W-1:0] ev;
  reg  [`PIEB_EV_W-1:0] clr;
  wire [`PIEB_EV_W-1:0] nxt_stat;

  always @* begin
    ev  = {`PIEB_EV_W{1'b0}};
    clr = {`PIEB_EV_W{1'b0}};
    ev[`PIEB_EV_REQ_RISE] = O_PERIPH_REQ & ~req_d_ff;
    // flags an enable-register write whose data touched a read-only or unused position
    ev[`PIEB_EV_RO_WRITE] = wr & lane0 & ((wdat & ~cur_mask) != 8'h00) &
                            (adr_w <= `PIEB_OFS_EN5); // RULE16
    ev[`PIEB_EV_UNMAPPED] = start & ~is_mapped(adr_w);
    if (wr && lane0 && adr_w == `PIEB_OFS_CLR) begin
      clr = wdat[`PIEB_EV_W-1:0];
    end
  end

  // a new event beats a clear in the same cycle
  assign nxt_stat = (stat_ff & ~clr) | ev;

  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      stat_ff  <= `PIEB_EV_RST;
      req_d_ff <= 1'b0;
    end else begin
      stat_ff  <= nxt_stat;
      req_d_ff <= O_PERIPH_REQ;
    end
  end

  assign O_IRQ = |(stat_ff & irqen_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the request cycle and held with ack

  reg  [7:0]  rsel;
  reg  [31:0] rdat_ff;

  always @* begin
    case (adr_w)
      `PIEB_OFS_EN1:   rsel = en1_ff; // RULE7
      `PIEB_OFS_EN2:   rsel = en2_ff; // RULE7
      `PIEB_OFS_EN3:   rsel = en3_ff;
      `PIEB_OFS_EN4:   rsel = en4_ff;
      `PIEB_OFS_EN5:   rsel = en5_ff;
      `PIEB_OFS_STAT:  rsel = {{(8-`PIEB_EV_W){1'b0}}, stat_ff};
      `PIEB_OFS_IRQEN: rsel = {{(8-`PIEB_EV_W){1'b0}}, irqen_ff};
      `PIEB_OFS_CTRL:  rsel = {6'h00, ctrl_ff};
      default:         rsel = 8'h00;
    endcase
  end

  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdat_ff <= 32'h0000_0000;
    end else if (start) begin
      rdat_ff <= {24'h00_0000, rsel};
    end
  end

  assign O_WB_DAT = rdat_ff;

endmodule // pieb_top

// ---- pieb_chk_sva.sv ----
// port-level assertions and covers for the peripheral interrupt enable bank
`timescale 1ns/100ps
module pieb_chk #(
  parameter SMALL_VARIANT = 0                 // matches the design's variant
) (
  input wire        I_CLK, I_SYS_RST,         // clock and sync reset
  input wire        I_WB_CYC, I_WB_STB,       // bus request
  input wire        I_WB_WE, O_WB_ACK,        // direction and answer
  input wire [31:0] O_WB_DAT,                 // read data
  input wire [1:0]  I_RX_BUF_RD,              // rx buffer read pulses
  input wire        I_DISP_TYPE_B,            // display waveform type
  input wire        I_DISP_NONSTATIC,         // display drive mode
  input wire [7:0]  I_FLAG1, I_FLAG2, I_FLAG3, I_FLAG4, I_FLAG5,          // flags
  input wire [7:0]  O_GATED1, O_GATED2, O_GATED3, O_GATED4, O_GATED5,     // gated
  input wire        O_PERIPH_REQ              // request to core
);
  wire [39:0] gates = {O_GATED5, O_GATED4, O_GATED3, O_GATED2, O_GATED1};
  wire [39:0] flags = {I_FLAG5, I_FLAG4, I_FLAG3, I_FLAG2, I_FLAG1};
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  a_ack_next_edge: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("ack did not follow request");
  a_dat_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unused_bits_zero: assert property (!O_GATED1[7] && !O_GATED2[6])
    else $error("unused position passed a flag");
  a_serial2_blocked: assert property (O_GATED3[5:4] == 2'h0)
    else $error("port2 serial source passed");
  a_gate_needs_flag: assert property ((gates & ~flags) == 40'h0)
    else $error("gated bit without flag");
  a_req_has_source: assert property (O_PERIPH_REQ |-> gates != 40'h0)
    else $error("request without gated source");
  a_disp_mode_gate: assert property (!(I_DISP_TYPE_B && I_DISP_NONSTATIC) |-> !O_GATED3[6])
    else $error("display source passed outside its mode");
  a_rx_read_drops: assert property (I_RX_BUF_RD[0] |-> !O_GATED1[5])
    else $error("rx source passed during buffer read");
  a_small_masked: assert property (SMALL_VARIANT != 0 |-> O_GATED4[7:6] == 2'h0 && (O_GATED5 & 8'he8) == 8'h0)
    else $error("small variant passed missing source");
  c_req: cover property (O_PERIPH_REQ);
  c_write: cover property (I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK);
  c_req_fall: cover property ($fell(O_PERIPH_REQ));
endmodule // pieb_chk
bind pieb_top pieb_chk #(.SMALL_VARIANT(SMALL_VARIANT)) u_pieb_chk (.*);

// ---- pieb_flag_src.sv ----
// flag register model: events set bits, software clears them
`timescale 1ns/100ps
module pieb_flag_src (
  input  wire logic        i_clk,             // system clock
  input  wire logic        i_rst,             // sync reset
  input  wire logic [39:0] i_set,             // event pulses
  input  wire logic [39:0] i_clr,             // software clear pulses
  output logic      [39:0] o_flag_ff          // flag contents
);
  // flags are sticky: the hardware only sets, software must clear
  always @(posedge i_clk) begin
    if (i_rst) o_flag_ff <= 40'h0;
    else o_flag_ff <= (o_flag_ff & ~i_clr) | i_set;
  end
endmodule // pieb_flag_src

// ---- peripheral_interrupt_enable_bank_test.sv ----
// self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/100ps
module peripheral_interrupt_enable_bank_test;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, dtb = 1, dns = 1;
  logic [7:0]  adr = 8'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, q;
  logic [1:0]  rxrd = 2'h0, txwr = 2'h0;
  logic [39:0] fset = 40'h0, fclr = 40'h0, fl;
  wire  [31:0] rdat;
  wire         ack, req, irq;
  wire  [39:0] g;
  wire  [39:0] gs;
  wire  [31:0] rdat_s;
  int          failures = 0, samples_checked = 0;
  // rows: offset, write data, expected gated byte with all flags up
  logic [23:0] rows [7] = '{24'h00ff7f, 24'h04ffbf, 24'h08ffcf, 24'h0cffff,
                            24'h10ffff, 24'h044404, 24'h000000};
  pieb_flag_src u_pieb_flag_src (.i_clk(clk), .i_rst(rst), .i_set(fset), .i_clr(fclr),
    .o_flag_ff(fl));
  pieb_top u_pieb_top (.I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_FLAG1(fl[7:0]), .I_FLAG2(fl[15:8]), .I_FLAG3(fl[23:16]),
    .I_FLAG4(fl[31:24]), .I_FLAG5(fl[39:32]), .I_RX_BUF_RD(rxrd), .I_TX_BUF_WR(txwr),
    .I_DISP_TYPE_B(dtb), .I_DISP_NONSTATIC(dns), .O_GATED1(g[7:0]), .O_GATED2(g[15:8]),
    .O_GATED3(g[23:16]), .O_GATED4(g[31:24]), .O_GATED5(g[39:32]),
    .O_PERIPH_REQ(req), .O_IRQ(irq));
  // small variant on the same bus and flags, so its missing positions are exercised
  pieb_top #(.SMALL_VARIANT(1)) u_pieb_top_small (.I_CLK(clk), .I_SYS_RST(rst),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(dat), .O_WB_DAT(rdat_s), .O_WB_ACK(), .I_FLAG1(fl[7:0]),
    .I_FLAG2(fl[15:8]), .I_FLAG3(fl[23:16]), .I_FLAG4(fl[31:24]), .I_FLAG5(fl[39:32]),
    .I_RX_BUF_RD(rxrd), .I_TX_BUF_WR(txwr), .I_DISP_TYPE_B(dtb), .I_DISP_NONSTATIC(dns),
    .O_GATED1(gs[7:0]), .O_GATED2(gs[15:8]), .O_GATED3(gs[23:16]), .O_GATED4(gs[31:24]),
    .O_GATED5(gs[39:32]), .O_PERIPH_REQ(), .O_IRQ());
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  // one classic cycle; waits for ack, bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; dat <= {24'h0, d};
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (n >= 20) chk(1'b0, 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(0, 8'h00, 8'h0); chk(q, 0); chk({irq, req}, 0);
    @(posedge clk) fset <= {40{1'b1}};
    @(posedge clk) fset <= 40'h0;
    wb(1, 8'h20, 8'h01);
    foreach (rows[i]) begin
      wb(1, rows[i][23:16], rows[i][15:8]);
      chk(g[rows[i][20:18]*8 +: 8], rows[i][7:0]);
      wb(0, rows[i][23:16], 8'h0); chk(q, rows[i][7:0]);
    end
    chk(req, 1);
    chk(gs[39:24], 16'h173f);
    wb(0, 8'h0c, 8'h0); chk(rdat_s, 8'h3f); chk(q, 8'hff);
    $display("table rows done");
    wb(1, 8'h20, 8'h00); chk(req, 0);
    wb(1, 8'h20, 8'h02); chk(req, 1);
    @(posedge clk) dtb <= 1'b0;
    @(negedge clk) chk(g[22], 0);
    @(posedge clk) begin dtb <= 1'b1; dns <= 1'b0; end
    @(negedge clk) chk(g[22], 0);
    wb(1, 8'h00, 8'h30);
    @(posedge clk) begin rxrd <= 2'h1; txwr <= 2'h1; end
    @(negedge clk) chk(g[5:4], 0);
    @(posedge clk) begin rxrd <= 2'h0; txwr <= 2'h0; end
    @(negedge clk) chk(g[5:4], 2'h3);
    wb(1, 8'h24, 8'hff); wb(0, 8'h24, 8'h0); chk(q, 0);
    wb(0, 8'h14, 8'h0); chk(q, 7);
    wb(1, 8'h1c, 8'h01); chk(irq, 1);
    wb(1, 8'h1c, 8'h00); chk(irq, 0);
    wb(1, 8'h1c, 8'h01); wb(1, 8'h18, 8'h07); wb(0, 8'h14, 8'h0); chk(q, 0); chk(irq, 0);
    $display("interrupt done");
    @(posedge clk) fclr <= {40{1'b1}};
    @(posedge clk) fclr <= 40'h0;
    @(negedge clk) chk(g, 0);
    chk(req, 0);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(0, 8'h08, 8'h0); chk(q, 0);
    $display("reset done");
    tally_and_finish;
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish;
  end
endmodule // peripheral_interrupt_enable_bank_test
